// ---- valve_open_close_timer.sv ----
// Implementation choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module valve_open_close_timer #(
  parameter int unsigned TICK_CYCLES = valve_pkg::TICK_CYCLES
) (
  // clock and reset
  input  wire logic                  core_clk_in,
  input  wire logic                  srst_in,
  // register bus
  input  wire valve_pkg::axil_req_t  axil_req_in,
  output valve_pkg::axil_rsp_t       axil_rsp_out,
  // control loop power, percent
  input  wire logic [7:0]            heat_power_in,
  input  wire logic [7:0]            cool_power_in,
  // valve contacts
  output logic                       close_drive_out,
  output logic                       open_drive_out
);

  valve_pkg::core_state_t st;
  valve_pkg::core_state_t next_st;
  logic                   tick;
  logic [6:0]             req_pct;
  logic [6:0]             db_pct;
  logic [6:0]             diff_pct;
  logic [6:0]             run_pct;
  logic [23:0]            run_ticks;
  logic                   want_run;
  logic [7:0]             rd_addr;

  function automatic logic [6:0] clamp_pct(input logic [7:0] v);
    clamp_pct = (v > {1'b0, valve_pkg::PCT_FULL}) ? valve_pkg::PCT_FULL : v[6:0];
  endfunction : clamp_pct

  function automatic logic [23:0] pct_ticks(input logic [6:0] pct, input logic [15:0] trav);
    // one tick is 10 ms, so pct/100 * seconds equals pct * seconds ticks
    pct_ticks = 24'(pct) * 24'(trav);
  endfunction : pct_ticks

  function automatic logic [31:0] merge_strb(input logic [31:0] old, input logic [31:0] d,
                                             input logic [3:0] strb);
    for (int i = 0; i < 4; i++) begin
      merge_strb[i*8 +: 8] = strb[i] ? d[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction : merge_strb

  valve_tick #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_tick (
    .core_clk_in (core_clk_in),
    .srst_in     (srst_in),
    .tick_out    (tick)
  );

  always_comb begin
    req_pct   = clamp_pct(st.src_cool ? cool_power_in : heat_power_in);
    db_pct    = clamp_pct(st.dband);
    diff_pct  = (req_pct > st.position) ? 7'(req_pct - st.position)
                                        : 7'(st.position - req_pct);
    // small errors inside half the dead band are left alone so a short
    // minimum run cannot overshoot and start a reverse run
    want_run  = st.enable && (st.travel != 16'h0000) && (diff_pct != 7'h00) &&
                (diff_pct > (db_pct >> 1));
    run_pct   = (diff_pct > db_pct) ? diff_pct : db_pct;
    run_ticks = pct_ticks(run_pct, st.travel);
    rd_addr   = axil_req_in.araddr[7:0];
  end

  always_comb begin
    logic [31:0] ctrl_word;
    ctrl_word = 32'h0000_0000;
    next_st   = st;

    // write channel: address and data taken in either order
    if (axil_req_in.awvalid && !st.aw_got && !st.bvalid) begin
      next_st.aw_got  = 1'b1;
      next_st.aw_addr = axil_req_in.awaddr[7:0];
    end
    if (axil_req_in.wvalid && !st.w_got && !st.bvalid) begin
      next_st.w_got  = 1'b1;
      next_st.w_data = axil_req_in.wdata;
      next_st.w_strb = axil_req_in.wstrb;
    end
    if (st.aw_got && st.w_got) begin
      next_st.aw_got = 1'b0;
      next_st.w_got  = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp  = valve_pkg::RESP_OKAY;
      ctrl_word[valve_pkg::CTRL_ENABLE_BIT] = st.enable;
      ctrl_word[valve_pkg::CTRL_SRC_BIT]    = st.src_cool;
      if (st.aw_addr == valve_pkg::OFS_CTRL) begin
        ctrl_word = merge_strb(ctrl_word, st.w_data, st.w_strb);
        next_st.enable   = ctrl_word[valve_pkg::CTRL_ENABLE_BIT];
        next_st.src_cool = ctrl_word[valve_pkg::CTRL_SRC_BIT];
      end else if (st.aw_addr == valve_pkg::OFS_TRAVEL) begin
        next_st.travel = 16'(merge_strb({16'h0000, st.travel}, st.w_data, st.w_strb));
      end else if (st.aw_addr == valve_pkg::OFS_DBAND) begin
        next_st.dband = 8'(merge_strb({24'h00_0000, st.dband}, st.w_data, st.w_strb));
      end else if (st.aw_addr == valve_pkg::OFS_STATUS || st.aw_addr == valve_pkg::OFS_REMAIN) begin
        next_st.bresp = valve_pkg::RESP_OKAY;
      end else begin
        next_st.bresp = valve_pkg::RESP_SLVERR;
      end
    end
    if (st.bvalid && axil_req_in.bready) begin
      next_st.bvalid = 1'b0;
    end

    // read channel
    if (st.rvalid && axil_req_in.rready) begin
      next_st.rvalid = 1'b0;
    end
    if (axil_req_in.arvalid && !st.rvalid) begin
      next_st.rvalid = 1'b1;
      next_st.rresp  = valve_pkg::RESP_OKAY;
      next_st.rdata  = 32'h0000_0000;
      if (rd_addr == valve_pkg::OFS_CTRL) begin
        next_st.rdata[valve_pkg::CTRL_ENABLE_BIT] = st.enable;
        next_st.rdata[valve_pkg::CTRL_SRC_BIT]    = st.src_cool;
      end else if (rd_addr == valve_pkg::OFS_TRAVEL) begin
        next_st.rdata[15:0] = st.travel;
      end else if (rd_addr == valve_pkg::OFS_DBAND) begin
        next_st.rdata[7:0] = st.dband;
      end else if (rd_addr == valve_pkg::OFS_STATUS) begin
        next_st.rdata[valve_pkg::STAT_POS_LSB +: 7] = st.position;
        next_st.rdata[valve_pkg::STAT_CLOSE_BIT]    = (st.run == valve_pkg::RUN_CLOSE);
        next_st.rdata[valve_pkg::STAT_OPEN_BIT]     = (st.run == valve_pkg::RUN_OPEN);
      end else if (rd_addr == valve_pkg::OFS_REMAIN) begin
        next_st.rdata[23:0] = st.remaining;
      end else begin
        next_st.rresp = valve_pkg::RESP_SLVERR;
      end
    end

    // valve run sequencer
    case (st.run)
      valve_pkg::RUN_IDLE: begin
        if (want_run) begin
          next_st.remaining = run_ticks;
          next_st.min_ticks = pct_ticks(db_pct, st.travel);
          next_st.elapsed   = 24'h00_0000;
          next_st.frac      = 16'h0000;
          next_st.run       = (req_pct > st.position) ? valve_pkg::RUN_OPEN
                                                      : valve_pkg::RUN_CLOSE;
        end
      end
      valve_pkg::RUN_OPEN, valve_pkg::RUN_CLOSE: begin
        // the remaining count is never below the minimum, so ending
        // only at zero keeps every run at least the dead time
        if (st.remaining == 24'h00_0000) begin
          next_st.run = valve_pkg::RUN_IDLE;
        end else if (tick) begin
          next_st.remaining = 24'(st.remaining - 1'b1);
          next_st.elapsed   = 24'(st.elapsed + 1'b1);
          if (16'(st.frac + 1'b1) >= st.travel) begin
            next_st.frac = 16'h0000;
            // limit switches stop the motor at either end
            if (st.run == valve_pkg::RUN_OPEN && st.position < valve_pkg::PCT_FULL) begin
              next_st.position = 7'(st.position + 1'b1);
            end else if (st.run == valve_pkg::RUN_CLOSE && st.position != 7'h00) begin
              next_st.position = 7'(st.position - 1'b1);
            end
          end else begin
            next_st.frac = 16'(st.frac + 1'b1);
          end
        end
      end
      default: begin
        next_st.run = valve_pkg::RUN_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      st <= valve_pkg::CORE_RESET;
    end else begin
      st <= next_st;
    end
  end

  always_comb begin
    axil_rsp_out.awready = !st.aw_got && !st.bvalid;
    axil_rsp_out.wready  = !st.w_got && !st.bvalid;
    axil_rsp_out.bvalid  = st.bvalid;
    axil_rsp_out.bresp   = st.bresp;
    axil_rsp_out.arready = !st.rvalid;
    axil_rsp_out.rvalid  = st.rvalid;
    axil_rsp_out.rdata   = st.rdata;
    axil_rsp_out.rresp   = st.rresp;
    // one-hot run state makes both drives on at once impossible
    close_drive_out = (st.run == valve_pkg::RUN_CLOSE);
    open_drive_out  = (st.run == valve_pkg::RUN_OPEN);
  end

  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (srst_in);

  chk_drive_exclusive: assert property (!(open_drive_out && close_drive_out))
    else $error("open and close drives on together");
  chk_open_direction: assert property ($rose(open_drive_out) |->
    $past(req_pct) > $past(st.position))
    else $error("open run started without positive error");
  chk_close_direction: assert property ($rose(close_drive_out) |->
    $past(req_pct) < $past(st.position))
    else $error("close run started without negative error");
  chk_run_length: assert property ($rose(open_drive_out || close_drive_out) |->
    st.remaining == $past(run_ticks))
    else $error("run time not loaded from error and travel");
  chk_min_time: assert property ($fell(open_drive_out || close_drive_out) |->
    $past(st.elapsed) >= $past(st.min_ticks))
    else $error("drive released before the minimum run time");
  chk_min_load: assert property ($rose(open_drive_out || close_drive_out) |->
    st.min_ticks == 24'($past(db_pct)) * 24'($past(st.travel)))
    else $error("minimum run time not dead band times travel");
  chk_hold_drive: assert property ((open_drive_out && st.remaining != 24'h00_0000) |=>
    open_drive_out)
    else $error("open drive dropped with time left");
  chk_pos_range: assert property (st.position <= valve_pkg::PCT_FULL)
    else $error("position above full scale");
  chk_open_moves: assert property ((open_drive_out && tick && st.remaining != 24'h00_0000 &&
    16'(st.frac + 1'b1) >= st.travel && st.position < valve_pkg::PCT_FULL) |=>
    st.position == 7'($past(st.position) + 1'b1))
    else $error("open run did not raise position");
  chk_reset_state: assert property ($past(srst_in) |->
    (st.position == 7'h00 && st.elapsed == 24'h00_0000 && !open_drive_out))
    else $error("state not closed and zero after reset");

  cov_open_run: cover property ($fell(open_drive_out));
  cov_close_run: cover property ($fell(close_drive_out));
  cov_min_extended: cover property ($rose(open_drive_out || close_drive_out) &&
    st.remaining == st.min_ticks);
  cov_full_open: cover property (st.position == valve_pkg::PCT_FULL);

endmodule : valve_open_close_timer

// ---- valve_pkg.sv ----
package valve_pkg;

  // clock and time base
  localparam int unsigned CLK_PERIOD_NS  = 8;
  localparam int unsigned TICK_PERIOD_NS = 10_000_000;
  localparam int unsigned TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;

  // percent scale of the position and power values
  localparam logic [6:0] PCT_FULL = 7'h64;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_TRAVEL = 8'h04;
  localparam logic [7:0] OFS_DBAND  = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_REMAIN = 8'h10;

  // field positions
  localparam int unsigned CTRL_ENABLE_BIT  = 0;
  localparam int unsigned CTRL_SRC_BIT     = 1;
  localparam int unsigned STAT_POS_LSB     = 0;
  localparam int unsigned STAT_CLOSE_BIT   = 8;
  localparam int unsigned STAT_OPEN_BIT    = 9;

  // reset values
  localparam logic [15:0] TRAVEL_RST = 16'h003C;
  localparam logic [7:0]  DBAND_RST  = 8'h02;

  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    RUN_IDLE  = 3'b001,
    RUN_OPEN  = 3'b010,
    RUN_CLOSE = 3'b100
  } run_state_t;

  typedef struct packed {
    logic        awvalid;
    logic [31:0] awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [31:0] araddr;
    logic        rready;
  } axil_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axil_rsp_t;

  typedef struct packed {
    logic        aw_got;
    logic        w_got;
    logic [7:0]  aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
    logic        enable;
    logic        src_cool;
    logic [15:0] travel;
    logic [7:0]  dband;
    run_state_t  run;
    logic [6:0]  position;
    logic [23:0] remaining;
    logic [23:0] min_ticks;
    logic [23:0] elapsed;
    logic [15:0] frac;
  } core_state_t;

  localparam core_state_t CORE_RESET = '{
    aw_got: 1'b0, w_got: 1'b0, aw_addr: 8'h00, w_data: 32'h0000_0000,
    w_strb: 4'h0, bvalid: 1'b0, bresp: 2'h0, rvalid: 1'b0, rresp: 2'h0,
    rdata: 32'h0000_0000, enable: 1'b0, src_cool: 1'b0,
    travel: TRAVEL_RST, dband: DBAND_RST, run: RUN_IDLE,
    position: 7'h00, remaining: 24'h00_0000, min_ticks: 24'h00_0000,
    elapsed: 24'h00_0000, frac: 16'h0000
  };

endpackage : valve_pkg

// ---- valve_tick.sv ----
`timescale 1ns/1ps
module valve_tick #(
  parameter int unsigned TICK_CYCLES = valve_pkg::TICK_CYCLES
) (
  // clock and reset
  input  wire logic core_clk_in,
  input  wire logic srst_in,
  // time base
  output logic      tick_out
);

  localparam int unsigned CW = $clog2(TICK_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(TICK_CYCLES - 1);

  logic [CW-1:0] count;
  logic [CW-1:0] next_count;
  logic          next_tick;

  always_comb begin
    next_tick  = (count == LAST);
    next_count = next_tick ? '0 : CW'(count + 1'b1);
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      count    <= '0;
      tick_out <= 1'b0;
    end else begin
      count    <= next_count;
      tick_out <= next_tick;
    end
  end

endmodule : valve_tick

// ---- valve_model.sv ----
`timescale 1ns/1ps
module valve_model #(
  parameter int unsigned FULL_CYC = 400
) (
  // clock
  input  wire logic core_clk_in,
  // contacts
  input  wire logic close_in,
  input  wire logic open_in,
  // observed state
  output int unsigned pos_cyc_out,
  output logic        overlap_out
);
  int unsigned pos = 0;
  logic        ovl = 1'b0;

  assign pos_cyc_out = pos;
  assign overlap_out = ovl;

  // travel limit switches stop the motor at both ends, so the count saturates
  always @(posedge core_clk_in) begin
    if (open_in && close_in) begin
      ovl <= 1'b1;
    end else if (open_in && pos < FULL_CYC) begin
      pos <= pos + 1;
    end else if (close_in && pos > 0) begin
      pos <= pos - 1;
    end
  end
endmodule : valve_model

// ---- valve_open_close_timer_tb_top.sv ----
`timescale 1ns/1ps
module valve_open_close_timer_tb_top;
  localparam int unsigned TK = 4;
  logic                 core_clk_in;
  logic                 srst_in;
  valve_pkg::axil_req_t req;
  valve_pkg::axil_rsp_t rsp;
  logic [7:0]           heat;
  logic [7:0]           cool;
  logic                 close_drv;
  logic                 open_drv;
  int unsigned          valve_pos;
  logic                 overlap;
  int                   errors = 0;
  int                   num_checks = 0;
  int                   cyc = 0;

  valve_open_close_timer #(.TICK_CYCLES(TK)) uut (
    .core_clk_in(core_clk_in), .srst_in(srst_in), .axil_req_in(req), .axil_rsp_out(rsp),
    .heat_power_in(heat), .cool_power_in(cool), .close_drive_out(close_drv),
    .open_drive_out(open_drv));
  valve_model #(.FULL_CYC(400)) valve (
    .core_clk_in(core_clk_in), .close_in(close_drv), .open_in(open_drv),
    .pos_cyc_out(valve_pos), .overlap_out(overlap));

  initial begin
    core_clk_in = 1'b0;
    forever #4 core_clk_in = ~core_clk_in;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask : check

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : report_and_stop

  // the bus may hold bready high early; the slave answers only after both halves
  // handshakes are judged mid-cycle, where ready and valid are settled for the next edge
  task automatic bus_write(input logic [7:0] addr, input logic [31:0] data,
                           input logic [1:0] exp_resp);
    bit         aw_hit;
    bit         w_hit;
    bit         b_hit;
    logic [1:0] resp;
    req.awvalid <= 1'b1;
    req.awaddr <= {24'h00_0000, addr};
    req.wvalid <= 1'b1;
    req.wdata <= data;
    req.wstrb <= 4'hF;
    req.bready <= 1'b1;
    do begin
      @(negedge core_clk_in);
      aw_hit = req.awvalid && (rsp.awready === 1'b1);
      w_hit  = req.wvalid && (rsp.wready === 1'b1);
      b_hit  = (rsp.bvalid === 1'b1);
      resp   = rsp.bresp;
      @(posedge core_clk_in);
      if (aw_hit) begin
        req.awvalid <= 1'b0;
      end
      if (w_hit) begin
        req.wvalid <= 1'b0;
      end
    end while (!b_hit);
    req.bready <= 1'b0;
    @(posedge core_clk_in);
    check({30'h0, resp}, {30'h0, exp_resp}, "write response");
  endtask : bus_write

  task automatic rd_chk(input logic [7:0] addr, input logic [31:0] exp,
                        input logic [1:0] exp_resp);
    bit          ar_hit;
    bit          r_hit;
    logic [31:0] data;
    logic [1:0]  resp;
    req.arvalid <= 1'b1;
    req.araddr <= {24'h00_0000, addr};
    req.rready <= 1'b1;
    do begin
      @(negedge core_clk_in);
      ar_hit = req.arvalid && (rsp.arready === 1'b1);
      r_hit  = (rsp.rvalid === 1'b1);
      data   = rsp.rdata;
      resp   = rsp.rresp;
      @(posedge core_clk_in);
      if (ar_hit) begin
        req.arvalid <= 1'b0;
      end
    end while (!r_hit);
    req.rready <= 1'b0;
    @(posedge core_clk_in);
    check(data, exp, "read data");
    check({30'h0, resp}, {30'h0, exp_resp}, "read response");
  endtask : rd_chk

  // run length in clocks: tick phase is free, so one tick of slack below
  task automatic run_check(input bit open_dir, input int lo, input int hi);
    int n;
    int w;
    w = 0;
    n = 0;
    // drives are sampled mid-cycle, away from the edge that launches them
    @(negedge core_clk_in);
    while ((open_dir ? open_drv : close_drv) !== 1'b1 && w < 20) begin
      @(negedge core_clk_in);
      w++;
    end
    while ((open_dir ? open_drv : close_drv) === 1'b1 && n < 200) begin
      check({31'h0, open_dir ? close_drv : open_drv}, 32'h0000_0000, "opposite drive");
      @(negedge core_clk_in);
      n++;
    end
    check({31'h0, n >= lo && n <= hi}, 32'h0000_0001, "run length");
    @(posedge core_clk_in);
  endtask : run_check

  task automatic test_reset_values();
    rd_chk(valve_pkg::OFS_CTRL, 32'h0000_0000, valve_pkg::RESP_OKAY);
    rd_chk(valve_pkg::OFS_TRAVEL, 32'h0000_003C, valve_pkg::RESP_OKAY);
    rd_chk(valve_pkg::OFS_DBAND, 32'h0000_0002, valve_pkg::RESP_OKAY);
    rd_chk(valve_pkg::OFS_STATUS, 32'h0000_0000, valve_pkg::RESP_OKAY);
    rd_chk(valve_pkg::OFS_REMAIN, 32'h0000_0000, valve_pkg::RESP_OKAY);
    bus_write(valve_pkg::OFS_STATUS, 32'h0000_03FF, valve_pkg::RESP_OKAY);
    rd_chk(valve_pkg::OFS_STATUS, 32'h0000_0000, valve_pkg::RESP_OKAY);
    rd_chk(8'h14, 32'h0000_0000, valve_pkg::RESP_SLVERR);
    bus_write(8'h14, 32'h0000_0005, valve_pkg::RESP_SLVERR);
    $display("test reset_values done");
  endtask : test_reset_values

  task automatic test_open_close();
    heat <= 8'h03;
    bus_write(valve_pkg::OFS_TRAVEL, 32'h0000_0001, valve_pkg::RESP_OKAY);
    bus_write(valve_pkg::OFS_CTRL, 32'h0000_0001, valve_pkg::RESP_OKAY);
    run_check(1'b1, 2 * TK + 1, 3 * TK + 2);
    rd_chk(valve_pkg::OFS_STATUS, 32'h0000_0003, valve_pkg::RESP_OKAY);
    check({31'h0, valve_pos > 0}, 32'h0000_0001, "valve moved");
    heat <= 8'h00;
    run_check(1'b0, 2 * TK + 1, 3 * TK + 2);
    rd_chk(valve_pkg::OFS_STATUS, 32'h0000_0000, valve_pkg::RESP_OKAY);
    $display("test open_close done");
  endtask : test_open_close

  task automatic test_min_run();
    bus_write(valve_pkg::OFS_CTRL, 32'h0000_0000, valve_pkg::RESP_OKAY);
    bus_write(valve_pkg::OFS_DBAND, 32'h0000_000A, valve_pkg::RESP_OKAY);
    heat <= 8'h06;
    bus_write(valve_pkg::OFS_CTRL, 32'h0000_0001, valve_pkg::RESP_OKAY);
    run_check(1'b1, 9 * TK + 1, 10 * TK + 2);
    rd_chk(valve_pkg::OFS_STATUS, 32'h0000_000A, valve_pkg::RESP_OKAY);
    // an error inside half the dead band must not start a run
    heat <= 8'h0C;
    repeat (8) @(posedge core_clk_in);
    rd_chk(valve_pkg::OFS_STATUS, 32'h0000_000A, valve_pkg::RESP_OKAY);
    $display("test min_run done");
  endtask : test_min_run

  task automatic test_cool_source();
    bus_write(valve_pkg::OFS_CTRL, 32'h0000_0000, valve_pkg::RESP_OKAY);
    bus_write(valve_pkg::OFS_TRAVEL, 32'h0000_0002, valve_pkg::RESP_OKAY);
    bus_write(valve_pkg::OFS_DBAND, 32'h0000_0002, valve_pkg::RESP_OKAY);
    cool <= 8'h07;
    bus_write(valve_pkg::OFS_CTRL, 32'h0000_0003, valve_pkg::RESP_OKAY);
    run_check(1'b0, 5 * TK + 1, 6 * TK + 2);
    rd_chk(valve_pkg::OFS_STATUS, 32'h0000_0007, valve_pkg::RESP_OKAY);
    check({31'h0, overlap}, 32'h0000_0000, "drives overlapped");
    rd_chk(valve_pkg::OFS_CTRL, 32'h0000_0003, valve_pkg::RESP_OKAY);
    $display("test cool_source done");
  endtask : test_cool_source

  // whole run is a few hundred clocks; the ceiling leaves ample margin
  always @(posedge core_clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      errors++;
      $display("ERROR %0t run timed out", $time);
      report_and_stop();
    end
  end

  initial begin
    srst_in = 1'b1;
    req = '0;
    heat = 8'h00;
    cool = 8'h00;
    repeat (20) @(posedge core_clk_in);
    srst_in <= 1'b0;
    @(posedge core_clk_in);
    test_reset_values();
    test_open_close();
    test_min_run();
    test_cool_source();
    report_and_stop();
  end
endmodule : valve_open_close_timer_tb_top
